// File: lane_sync_kchar_status.v
// Purpose: per-lane sync and control character error status, link paged
// Assumes: lane inputs come from another domain, so they are synchronised
// Notes: read data appears the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "lane_status_defines.vh"
module lane_sync_kchar_status #(
  parameter LANES = 8
) (
  input wire clk_sys,
  input wire rstn,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire [LANES-1:0] link0_ctrl_char_err,
  input wire [LANES-1:0] link0_group_lock,
  input wire [LANES-1:0] link1_ctrl_char_err,
  input wire [LANES-1:0] link1_group_lock
);
  reg link_page;
  reg [7:0] error_count_limit;
  reg [1:0] count_clear;
  reg [LANES-1:0] e0_a, e0_b, e1_a, e1_b, l0_a, l0_b, l1_a, l1_b;
  reg [LANES-1:0] e0_prev, e1_prev;
  wire [LANES-1:0] flag0, flag1;

  ////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; error input pulses are edge counted
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      e0_a <= {LANES{1'b0}};
      e0_b <= {LANES{1'b0}};
      e1_a <= {LANES{1'b0}};
      e1_b <= {LANES{1'b0}};
      l0_a <= {LANES{1'b0}};
      l0_b <= {LANES{1'b0}};
      l1_a <= {LANES{1'b0}};
      l1_b <= {LANES{1'b0}};
      e0_prev <= {LANES{1'b0}};
      e1_prev <= {LANES{1'b0}};
    end else begin
      e0_a <= link0_ctrl_char_err;
      e0_b <= e0_a;
      e1_a <= link1_ctrl_char_err;
      e1_b <= e1_a;
      l0_a <= link0_group_lock;
      l0_b <= l0_a;
      l1_a <= link1_group_lock;
      l1_b <= l1_a;
      e0_prev <= e0_b;
      e1_prev <= e1_b;
    end
  end

  ////////////////////////////////////////////////////////////////
  // One counter per lane per link
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      lane_error_counter #(.CW(8)) cnt0 (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .err_seen(e0_b[g] & ~e0_prev[g]),
        .clear(count_clear[0]),
        .limit(error_count_limit),
        .flag(flag0[g])
      );
      lane_error_counter #(.CW(8)) cnt1 (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .err_seen(e1_b[g] & ~e1_prev[g]),
        .clear(count_clear[1]),
        .limit(error_count_limit),
        .flag(flag1[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Control registers; status registers take no writes
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      link_page <= `RST_LINK_PAGE;
      error_count_limit <= `RST_ERROR_LIMIT;
      count_clear <= 2'b00;
    end else begin
      count_clear <= 2'b00;
      if (wr) begin
        if (addr == `ADDR_LINK_PAGE) begin
          link_page <= wdata[0];
        end else if (addr == `ADDR_ERROR_LIMIT) begin
          error_count_limit <= wdata[7:0];
        end else if (addr == `ADDR_COUNT_CLEAR) begin
          count_clear <= wdata[1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read port, paged by link select
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      if (addr == `ADDR_LINK_PAGE) begin
        rdata <= {31'h00000000, link_page};
      end else if (addr == `ADDR_ERROR_LIMIT) begin
        rdata <= {24'h000000, error_count_limit};
      end else if (addr == `ADDR_CTRL_CHAR_ERR) begin
        rdata <= {24'h000000, (link_page ? flag1[7:0] : flag0[7:0])};
      end else if (addr == `ADDR_GROUP_LOCK) begin
        rdata <= {24'h000000, (link_page ? l1_b[7:0] : l0_b[7:0])};
      end else begin
        rdata <= 32'h00000000;
      end
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// File: lane_status_defines.vh
// Purpose: constants for the per-lane link status block
// Assumes: plain register port, 32-bit read data, byte offsets as printed
// Notes: two links, each with its own lane status page
// Summary of operation
// - Flag set when lane count reaches limit
// - Lanes 2..0 occupy error bits 2..0
// - Lock register, one bit per lane, eight lanes
// - Lock bit one while lane holds sync
// - Reads show only the selected link page
// - Status resets to zero, writes ignored
// - Lanes 7..3 occupy error bits 7..3
`ifndef LANE_STATUS_DEFINES_VH
`define LANE_STATUS_DEFINES_VH
`define ADDR_LINK_PAGE 12'h300
`define ADDR_ERROR_LIMIT 12'h301
`define ADDR_COUNT_CLEAR 12'h302
`define ADDR_CTRL_CHAR_ERR 12'h46f
`define ADDR_GROUP_LOCK 12'h470
`define RST_STATUS 8'h00
`define RST_ERROR_LIMIT 8'hff
`define RST_LINK_PAGE 1'b0
`endif

// File: lane_error_counter.v
// Purpose: one lane's saturating control character error counter
// Assumes: error and clear are synchronous to clk_sys
// Notes: saturates so the flag never wraps back to zero
`timescale 1ns/1ps
`default_nettype none
module lane_error_counter #(
  parameter CW = 8
) (
  input wire clk_sys,
  input wire rstn,
  input wire err_seen,
  input wire clear,
  input wire [CW-1:0] limit,
  output reg flag
);
  reg [CW-1:0] count;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count <= {CW{1'b0}};
      flag <= 1'b0;
    end else begin
      if (clear) begin
        count <= {CW{1'b0}};
      end else if (err_seen && count != {CW{1'b1}}) begin
        count <= count + {{(CW-1){1'b0}}, 1'b1};
      end
      flag <= (count >= limit);
    end
  end
endmodule
`default_nettype wire

// File: lane_status_assertions.sv
// Purpose: port checks. Assumes: one clock. Notes: a lock read must match one link's pins
`timescale 1ns/1ps
`default_nettype none
module lane_status_chk #(parameter LANES = 8) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [11:0] addr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [LANES-1:0] link0_group_lock,
  input wire logic [LANES-1:0] link1_group_lock
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence rd_of(logic [11:0] a); $past(rd) && $past(addr) == a; endsequence
  idle_zero_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
  // Pins pass two sync flops and the read register, so a read shows them three edges late
  lock_read_a: assert property (rd_of(12'h470) |-> rdata == $past(link0_group_lock, 3)
    || rdata == $past(link1_group_lock, 3)) else $error("lock read mismatch");
  err_upper_a: assert property (rd_of(12'h46f) |-> rdata[31:8] == 24'h000000)
    else $error("error read upper bits set");
  lock_upper_a: assert property (rd_of(12'h470) |-> rdata[31:8] == 24'h000000)
    else $error("lock read upper bits set");
  hole_read_a: assert property (rd_of(12'h0ff) |-> rdata == 32'h0) else $error("unmapped read");
  reset_zero_a: assert property (disable iff (1'b0) !rstn |-> rdata == 32'h0) else $error("reset rdata");
  cover property (rd_of(12'h46f) ##0 rdata != 32'h0);
  cover property (rd_of(12'h470) ##0 rdata != 32'h0);
  cover property (rd_of(12'h300));
endmodule
bind lane_sync_kchar_status lane_status_chk #(.LANES(LANES)) chk (.clk_sys, .rstn, .addr, .rd, .rdata,
  .link0_group_lock, .link1_group_lock);
`default_nettype wire

// File: lane_tx_model.sv
// Purpose: far side lane events. Assumes: bench requests. Notes: registered, so each edge is clean
`timescale 1ns/1ps
`default_nettype none
module lane_tx_model (
  input wire logic clk_sys,
  input wire logic [7:0] err_req,
  output logic [7:0] ctrl_char_err = 8'h00
);
  always @(posedge clk_sys) ctrl_char_err <= err_req;
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: lane status bench. Assumes: 40 MHz clock. Notes: reads queue their expected data
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 0, rstn = 0, wr = 0, rd = 0, rd_d = 0;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, rdata, q[$];
  logic [7:0] er = 0, lq0 = 0, lq1 = 0, ce0, pat[4] = '{8'hff, 8'hff, 8'h07, 8'hf8}, ex[4] = '{0, 0, 7, 8'hff};
  logic [7:0] er1 = 0, ce1;
  integer fails = 0, n_tests = 0, cyc = 0, seed = 89, i;
  lane_tx_model far1 (.clk_sys, .err_req(er1), .ctrl_char_err(ce1));
  lane_tx_model far (.clk_sys, .err_req(er), .ctrl_char_err(ce0));
  lane_sync_kchar_status uut (.clk_sys, .rstn, .addr, .wdata, .wr, .rd, .rdata, .link0_ctrl_char_err(ce0),
    .link0_group_lock(lq0), .link1_ctrl_char_err(ce1), .link1_group_lock(lq1));
  initial forever #12.5 clk_sys = ~clk_sys;
  task chk(input logic [31:0] s, x);
    n_tests++;
    if (s !== x) fails++;
    if (s !== x) $display("[FAIL] rdata exp %h got %h", x, s);
  endtask
  task give_verdict;
    $display("%0d checks %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) rd_d <= rd;
  always @(negedge clk_sys) begin
    cyc++;
    if (rd_d) chk(rdata, q.pop_front());
    if (cyc == 900) fails++;
    if (cyc == 900) give_verdict;
  end
  // Strobes drop for a cycle between accesses, so no strobe is driven twice at one edge
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    if (!w) q.push_back(d);
    @(posedge clk_sys);
    {wr, rd} <= 2'b00;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1;
    acc(1'b1, 12'h470, 32'hff);
    acc(1'b0, 12'h470, 0);
    acc(1'b0, 12'h0ff, 0);
    for (i = 0; i < 6; i++) begin
      {lq0, lq1} <= 16'($random(seed));
      acc(1'b1, 12'h300, ~i & 1);
      acc(1'b0, 12'h470, i % 2 ? lq0 : lq1);
    end
    $display("lock test done");
    acc(1'b1, 12'h301, 3);
    for (i = 0; i < 4; i++) begin
      er <= pat[i];
      er1 <= pat[i] & 8'h0f;
      @(posedge clk_sys);
      er <= 8'h00;
      er1 <= 8'h00;
      repeat (4) @(posedge clk_sys);
      acc(1'b0, 12'h46f, ex[i]);
    end
    $display("error test done");
    acc(1'b0, 12'h301, 3);
    acc(1'b1, 12'h300, 1);
    acc(1'b0, 12'h46f, 8'h0f);
    acc(1'b1, 12'h302, 1);
    acc(1'b1, 12'h300, 0);
    acc(1'b0, 12'h46f, 0);
    acc(1'b1, 12'h300, 1);
    acc(1'b0, 12'h46f, 8'h0f);
    $display("page and clear test done");
    repeat (2) @(posedge clk_sys);
    give_verdict;
  end
endmodule
`default_nettype wire
